// *** hdl/srx_pkg.sv ***
// constants and types shared by the sdi receive timing output stage
`default_nettype none
package srx_pkg;
   localparam int DATA_W = 20;
   localparam int SD_W = 10;
   localparam int LEN_W = 12;
   localparam int SCI_AW = 6;
   localparam int SCI_DW = 8;
   localparam logic [DATA_W-1:0] TRS_FIRST_HD = 20'hfffff;
   localparam logic [DATA_W-1:0] TRS_FIRST_SD = 20'h003ff;
   localparam int XYZ_MARK_BIT = 9;
   localparam int FIELD_BIT = 8;
   localparam int VBLANK_BIT = 7;
   localparam int HBLANK_BIT = 6;
   localparam logic [1:0] RATE_BOTH = 2'h0;
   localparam logic [1:0] RATE_SD_ONLY = 2'h3;
   localparam int LOCK_LINES = 3;
   localparam int WD_TIMEOUT_TICKS = 64;
   localparam int NUM_FMT = 6;
   localparam logic [3:0] FMT_NONE = 4'h0;
   localparam logic [LEN_W-1:0] FMT_LEN [NUM_FMT] =
      '{12'h6b4, 12'h6c0, 12'h898, 12'ha50, 12'h672, 12'h7bc};
   localparam logic FMT_HD [NUM_FMT] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
   localparam logic [3:0] FMT_CODE [NUM_FMT] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
   localparam logic [SCI_AW-1:0] SCI_ADDR_RATE = 6'h01;
   localparam logic [SCI_DW-1:0] SCI_VAL_SD = 8'h00;
   localparam logic [SCI_DW-1:0] SCI_VAL_HD = 8'h01;
   typedef enum logic [4:0] {
      SCI_IDLE = 5'b00001,
      SCI_WAIT = 5'b00010,
      SCI_WR = 5'b00100,
      SCI_RD = 5'b01000,
      SCI_CHK = 5'b10000
   } srx_sci_state_type;
endpackage
`default_nettype wire

// *** hdl/srx_sci_if.sv ***
// control link between the timing stage and its configuration sequencer
`timescale 1ns/1ps
`default_nettype none
interface srx_sci_if;
   logic tick;
   logic enable;
   logic start;
   logic rate_hd;
   logic busy;
   modport ctrl (output tick, output enable, output start, output rate_hd, input busy);
   modport prog (input tick, input enable, input start, input rate_hd, output busy);
endinterface
`default_nettype wire

// *** hdl/srx_sci_prog.sv ***
// configuration bus sequencer that reprograms the deserialiser rate
`timescale 1ns/1ps
`default_nettype none
module srx_sci_prog (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // control from the timing stage
   srx_sci_if.prog ctl,
   // configuration bus
   output logic sci_select,
   output logic sci_enable,
   output logic sci_read,
   output logic sci_write,
   output logic [srx_pkg::SCI_AW-1:0] sci_address,
   output logic [srx_pkg::SCI_DW-1:0] sci_write_data,
   input wire logic [srx_pkg::SCI_DW-1:0] sci_read_data
);
   import srx_pkg::*;
   srx_sci_state_type state_r;
   logic [SCI_DW-1:0] value_r;

   ////////////////////////////////////////////////////////////////////////////
   // sequence, paced by the watchdog tick, retried until read-back matches
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= SCI_IDLE;
         value_r <= SCI_VAL_SD;
      end else if (ctl.enable) begin
         if (ctl.start) begin
            state_r <= SCI_WAIT;
            value_r <= ctl.rate_hd ? SCI_VAL_HD : SCI_VAL_SD;
         end else begin
            case (state_r)
               SCI_IDLE: state_r <= SCI_IDLE;
               SCI_WAIT: if (ctl.tick) state_r <= SCI_WR;
               SCI_WR: state_r <= SCI_RD;
               SCI_RD: state_r <= SCI_CHK;
               SCI_CHK: state_r <= (sci_read_data == value_r) ? SCI_IDLE : SCI_WAIT;
               default: state_r <= SCI_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus strobes decoded from state; address and data held steady
   assign ctl.busy = (state_r != SCI_IDLE);
   assign sci_write = (state_r == SCI_WR);
   assign sci_read = (state_r == SCI_RD);
   assign sci_select = sci_write | sci_read;
   assign sci_enable = sci_write | sci_read;
   assign sci_address = SCI_ADDR_RATE;
   assign sci_write_data = value_r;

   property p_sci_strobe;
      @(posedge ref_clk) disable iff (!reset_n)
      sci_write && ctl.enable && !ctl.start |=> sci_read && sci_select && sci_enable;
   endproperty
   a_sci_strobe: assert property (p_sci_strobe) else $error("read-back must follow write");
endmodule
`default_nettype wire

// *** hdl/srx_phy_rx_timing_outputs.sv ***
// receive output stage: trs marking, blanking flags, lock, format, rate request
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - rate clock request low asks for sd reference, high asks for hd.
// - active-low asynchronous reset clears the whole core and the serdes quad.
// - clock enable low freezes every register in the core except the check run counter en_run_r, which clears.
// - 20-bit parallel output; for sd only the low 10 bits carry data.
// - an output clock is supplied, parallel output is synchronous to it.
// - video locked is high while locked to a valid stream, else low.
// - scan disable high holds video locked at its present value.
// - 4-bit format code, valid only while video locked is high.
// - rate indicator tells whether the output word is hd or sd.
// - trs marker high exactly while first trs word is on the output.
// - field takes timing status word field bit, right after that word.
// - vertical blank follows status word v bit, right after that word.
// - horizontal blank follows status word h bit, right after that word.
// - static watchdog clock paces watchdog and configuration programming.
// - config bus master: 6-bit address, 8-bit data both ways, strobes.
// - core-sourced reference clock inputs used only under their options.
// - rate select 00 scans both, 01 or 10 hd only, 11 sd only.
module srx_phy_rx_timing_outputs #(
   parameter int LOCK_LINES = srx_pkg::LOCK_LINES,
   parameter int WD_TIMEOUT_TICKS = srx_pkg::WD_TIMEOUT_TICKS,
   parameter bit TX_CORE_SOURCED_OPTION = 1'b0,
   parameter bit RX_CORE_SOURCED_OPTION = 1'b0
) (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic core_enable,
   input wire logic static_watchdog_clock,
   // deserialiser side
   input wire logic [srx_pkg::DATA_W-1:0] deser_data,
   output logic serdes_quad_reset,
   input wire logic tx_core_ref_clock,
   input wire logic rx_core_ref_clock,
   output logic serdes_tx_ref_clock,
   output logic serdes_rx_ref_clock,
   // scan control and clock request
   input wire logic scan_disable,
   input wire logic [1:0] rate_select,
   output logic rx_rate_clock_request,
   // video output
   output logic [srx_pkg::DATA_W-1:0] parallel_video_out,
   output logic parallel_video_clock,
   output logic high_rate_indicator,
   output logic trs_marker,
   output logic video_locked,
   output logic [3:0] format_code,
   output logic video_field,
   output logic vertical_blank,
   output logic horizontal_blank,
   // configuration bus
   output logic sci_select,
   output logic sci_enable,
   output logic sci_read,
   output logic sci_write,
   output logic [srx_pkg::SCI_AW-1:0] sci_address,
   output logic [srx_pkg::SCI_DW-1:0] sci_write_data,
   input wire logic [srx_pkg::SCI_DW-1:0] sci_read_data
);
   import srx_pkg::*;
   localparam int WD_W = $clog2(WD_TIMEOUT_TICKS + 1);
   localparam int LK_W = $clog2(LOCK_LINES + 1);
   localparam logic [WD_W-1:0] WD_LAST = WD_W'(WD_TIMEOUT_TICKS - 1);
   localparam logic [LK_W-1:0] LK_FULL = LK_W'(LOCK_LINES);
   localparam logic [LK_W-1:0] LK_LAST = LK_W'(LOCK_LINES - 1);

   logic wd_meta_r;
   logic wd_sync_r;
   logic wd_last_r;
   logic wd_tick;
   logic [WD_W-1:0] wd_cnt_r;
   logic wd_expire;
   logic rate_hd_r;
   logic rate_hd_nxt;
   logic rate_change;
   logic [DATA_W-1:0] in_word;
   logic [DATA_W-1:0] pipe_r [3];
   logic [2:0] hd_pipe_r;
   logic trs_found;
   logic [2:0] mark_d_r;
   logic xyz_on_out;
   logic line_end;
   logic [LEN_W-1:0] len_cnt_r;
   logic [LEN_W-1:0] last_len_r;
   logic [3:0] fmt_now;
   logic len_match;
   logic [LK_W-1:0] match_cnt_r;
   logic [2:0] en_run_r;

   srx_sci_if sci_ctl ();

   ////////////////////////////////////////////////////////////////////////////
   // lookup of line length against the known formats at the current rate
   function automatic logic [3:0] fmt_lookup(input logic [LEN_W-1:0] len, input logic hd);
      logic [3:0] code;
      code = FMT_NONE;
      for (int i = 0; i < NUM_FMT; i++) begin
         if (FMT_LEN[i] == len && FMT_HD[i] == hd) begin
            code = FMT_CODE[i];
         end
      end
      return code;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pass-through of reset and clocks
   assign serdes_quad_reset = !reset_n;
   assign parallel_video_clock = ref_clk;
   // unused option inputs are parked low rather than left floating into the serdes
   assign serdes_tx_ref_clock = TX_CORE_SOURCED_OPTION ? tx_core_ref_clock : 1'b0;
   assign serdes_rx_ref_clock = RX_CORE_SOURCED_OPTION ? rx_core_ref_clock : 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // watchdog clock sampled into the core domain, first stage read only by second
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wd_meta_r <= 1'b0;
         wd_sync_r <= 1'b0;
         wd_last_r <= 1'b0;
      end else if (core_enable) begin
         wd_meta_r <= static_watchdog_clock;
         wd_sync_r <= wd_meta_r;
         wd_last_r <= wd_sync_r;
      end
   end

   assign wd_tick = core_enable && wd_sync_r && !wd_last_r;
   assign wd_expire = wd_tick && (wd_cnt_r == WD_LAST);

   // a found trs or a rate switch restarts the watchdog, so the new rate settles
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wd_cnt_r <= '0;
      end else if (core_enable) begin
         if (trs_found || rate_change || wd_expire) begin
            wd_cnt_r <= '0;
         end else if (wd_tick) begin
            wd_cnt_r <= wd_cnt_r + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // rate scan: forced modes win, multi-rate flips only on a timeout while unlocked
   always_comb begin
      rate_hd_nxt = rate_hd_r;
      if (!scan_disable) begin
         if (rate_select == RATE_SD_ONLY) begin
            rate_hd_nxt = 1'b0;
         end else if (rate_select != RATE_BOTH) begin
            rate_hd_nxt = 1'b1;
         end else if (wd_expire && !video_locked) begin
            rate_hd_nxt = !rate_hd_r;
         end
      end
   end

   assign rate_change = core_enable && (rate_hd_nxt != rate_hd_r);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rate_hd_r <= 1'b0;
      end else if (core_enable) begin
         rate_hd_r <= rate_hd_nxt;
      end
   end

   assign rx_rate_clock_request = rate_hd_r;

   ////////////////////////////////////////////////////////////////////////////
   // three-word look-ahead so the marker can rise with the first trs word
   assign in_word = rate_hd_r ? deser_data : {{(DATA_W - SD_W){1'b0}}, deser_data[SD_W-1:0]};
   assign trs_found = (pipe_r[2] == (hd_pipe_r[2] ? TRS_FIRST_HD : TRS_FIRST_SD))
      && (pipe_r[1] == '0) && (pipe_r[0] == '0) && in_word[XYZ_MARK_BIT];

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pipe_r <= '{default: '0};
         hd_pipe_r <= 3'h0;
         parallel_video_out <= '0;
         high_rate_indicator <= 1'b0;
         trs_marker <= 1'b0;
         mark_d_r <= 3'h0;
      end else if (core_enable) begin
         pipe_r[0] <= in_word;
         pipe_r[1] <= pipe_r[0];
         pipe_r[2] <= pipe_r[1];
         hd_pipe_r <= {hd_pipe_r[1:0], rate_hd_r};
         parallel_video_out <= pipe_r[2];
         high_rate_indicator <= hd_pipe_r[2];
         trs_marker <= trs_found;
         mark_d_r <= {mark_d_r[1:0], trs_marker};
      end
   end

   assign xyz_on_out = mark_d_r[2];
   assign line_end = xyz_on_out && parallel_video_out[HBLANK_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // flags load on the edge after the status word and hold until the next one
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         video_field <= 1'b0;
         vertical_blank <= 1'b0;
         horizontal_blank <= 1'b0;
      end else if (core_enable && xyz_on_out) begin
         video_field <= parallel_video_out[FIELD_BIT];
         vertical_blank <= parallel_video_out[VBLANK_BIT];
         horizontal_blank <= parallel_video_out[HBLANK_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // line length between end-of-line codes identifies the source format
   assign fmt_now = fmt_lookup(len_cnt_r, high_rate_indicator);
   assign len_match = (len_cnt_r == last_len_r) && (fmt_now != FMT_NONE);

   // counter saturates so a dead input never wraps into a false length
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         len_cnt_r <= '0;
         last_len_r <= '0;
      end else if (core_enable) begin
         if (line_end) begin
            len_cnt_r <= LEN_W'(1);
            last_len_r <= len_cnt_r;
         end else if (len_cnt_r != '1) begin
            len_cnt_r <= len_cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         format_code <= FMT_NONE;
      end else if (core_enable && !scan_disable && line_end && len_match) begin
         format_code <= fmt_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // lock after matching lines; the counter restarts on every rate switch
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         video_locked <= 1'b0;
         match_cnt_r <= '0;
      end else if (core_enable && !scan_disable) begin
         if (rate_change || wd_expire) begin
            video_locked <= 1'b0;
            match_cnt_r <= '0;
         end else if (line_end) begin
            if (len_match) begin
               if (match_cnt_r != LK_FULL) begin
                  match_cnt_r <= match_cnt_r + 1'b1;
               end
               if (match_cnt_r >= LK_LAST && !sci_ctl.busy) begin
                  video_locked <= 1'b1;
               end
            end else begin
               video_locked <= 1'b0;
               match_cnt_r <= '0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // deserialiser reprogramming on every rate change
   assign sci_ctl.tick = wd_tick;
   assign sci_ctl.enable = core_enable;
   assign sci_ctl.start = rate_change;
   assign sci_ctl.rate_hd = rate_hd_nxt;

   srx_sci_prog u_sci_prog (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .ctl(sci_ctl.prog),
      .sci_select(sci_select),
      .sci_enable(sci_enable),
      .sci_read(sci_read),
      .sci_write(sci_write),
      .sci_address(sci_address),
      .sci_write_data(sci_write_data),
      .sci_read_data(sci_read_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks: run length of enabled cycles, for relations that look back
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         en_run_r <= 3'h0;
      end else if (!core_enable) begin
         en_run_r <= 3'h0;
      end else if (en_run_r != 3'h7) begin
         en_run_r <= en_run_r + 1'b1;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   property p_freeze;
      !core_enable |=> $stable(parallel_video_out) && $stable(video_locked)
         && $stable(rx_rate_clock_request) && $stable(trs_marker);
   endproperty
   a_freeze: assert property (p_freeze) else $error("core moved while disabled");

   property p_sd_upper;
      !high_rate_indicator |-> parallel_video_out[DATA_W-1:SD_W] == '0;
   endproperty
   a_sd_upper: assert property (p_sd_upper) else $error("sd word has upper bits set");

   property p_rate_word;
      en_run_r == 3'h7 |-> high_rate_indicator == $past(rx_rate_clock_request, 4);
   endproperty
   a_rate_word: assert property (p_rate_word) else $error("rate indicator out of step");

   property p_lock_req;
      video_locked |-> rx_rate_clock_request == high_rate_indicator;
   endproperty
   a_lock_req: assert property (p_lock_req) else $error("locked with wrong clock request");

   property p_trs_word;
      trs_marker |-> parallel_video_out == (high_rate_indicator ? TRS_FIRST_HD : TRS_FIRST_SD);
   endproperty
   a_trs_word: assert property (p_trs_word) else $error("marker without first trs word");

   property p_trs_next;
      trs_marker && core_enable |=> parallel_video_out == '0 && !trs_marker;
   endproperty
   a_trs_next: assert property (p_trs_next) else $error("trs second word not zero");

   property p_field;
      xyz_on_out && core_enable |=> video_field == $past(parallel_video_out[FIELD_BIT]);
   endproperty
   a_field: assert property (p_field) else $error("field not taken from status word");

   property p_vblank;
      xyz_on_out && core_enable |=> vertical_blank == $past(parallel_video_out[VBLANK_BIT]);
   endproperty
   a_vblank: assert property (p_vblank) else $error("vblank not taken from status word");

   property p_hblank;
      xyz_on_out && core_enable |=> horizontal_blank == $past(parallel_video_out[HBLANK_BIT]);
   endproperty
   a_hblank: assert property (p_hblank) else $error("hblank not taken from status word");

   property p_hold_flags;
      !xyz_on_out |=> $stable(video_field) && $stable(vertical_blank) && $stable(horizontal_blank);
   endproperty
   a_hold_flags: assert property (p_hold_flags) else $error("flags moved between status words");

   property p_lock_rise;
      $rose(video_locked) |-> $past(line_end) && $past(len_match);
   endproperty
   a_lock_rise: assert property (p_lock_rise) else $error("lock rose without a matching line");

   property p_lock_loss;
      wd_expire && !scan_disable |=> !video_locked;
   endproperty
   a_lock_loss: assert property (p_lock_loss) else $error("lock kept after watchdog timeout");

   property p_scan_hold;
      scan_disable |=> $stable(video_locked) && $stable(rx_rate_clock_request);
   endproperty
   a_scan_hold: assert property (p_scan_hold) else $error("lock changed while scan disabled");

   property p_fmt_change;
      $changed(format_code) |-> $past(line_end) && $past(len_match);
   endproperty
   a_fmt_change: assert property (p_fmt_change) else $error("format changed off a line end");

   property p_sd_only;
      rate_select == RATE_SD_ONLY && !scan_disable && core_enable |=> !rx_rate_clock_request;
   endproperty
   a_sd_only: assert property (p_sd_only) else $error("sd-only mode asked for hd clock");

   property p_req_first;
      $changed(rx_rate_clock_request) |-> !video_locked;
   endproperty
   a_req_first: assert property (p_req_first) else $error("locked across a rate change");

   c_lock: cover property ($rose(video_locked));
   c_rate_flip: cover property (rate_select == RATE_BOTH ##1 $changed(rx_rate_clock_request));
   c_hd_trs: cover property (trs_marker && high_rate_indicator);
endmodule
`default_nettype wire

// *** bench/srx_downstream_model.sv ***
// downstream capture and configuration bus responder beside the timing stage
`timescale 1ns/1ps
`default_nettype none
module srx_downstream_model (
   // capture side
   input wire logic parallel_video_clock,
   input wire logic video_locked,
   input wire logic [3:0] format_code,
   output logic [3:0] seen_format = 4'h0,
   // configuration bus
   input wire logic sci_select,
   input wire logic sci_read,
   input wire logic sci_write,
   input wire logic [srx_pkg::SCI_DW-1:0] sci_write_data,
   output logic [srx_pkg::SCI_DW-1:0] sci_read_data = 8'h00
);
   logic [srx_pkg::SCI_DW-1:0] cfg_r = 8'h00;
   // format code is only trusted while lock is up
   always_ff @(posedge parallel_video_clock) begin
      if (video_locked) seen_format <= format_code;
   end
   // idle bus toggles so a stale value never passes for read data
   always_ff @(posedge parallel_video_clock) begin
      if (sci_select && sci_write) cfg_r <= sci_write_data;
      sci_read_data <= (sci_select && sci_read) ? cfg_r : ~sci_read_data;
   end
endmodule
`default_nettype wire

// *** bench/srx_phy_rx_timing_outputs_tb_top.sv ***
// self-checking bench for the receive timing output stage
`timescale 1ns/1ps
`default_nettype none
module srx_phy_rx_timing_outputs_tb_top;
   import srx_pkg::*;
   logic ref_clk = 1'h0;
   logic reset_n = 1'h0;
   logic core_enable = 1'h1;
   logic static_watchdog_clock = 1'h0;
   logic [DATA_W-1:0] deser_data = 20'h0;
   logic tx_core_ref_clock = 1'h1;
   logic rx_core_ref_clock = 1'h1;
   logic scan_disable = 1'h0;
   logic [1:0] rate_select = RATE_SD_ONLY;
   logic [SCI_DW-1:0] sci_read_data;
   logic [SCI_DW-1:0] sci_write_data;
   logic [SCI_AW-1:0] sci_address;
   logic [DATA_W-1:0] parallel_video_out;
   logic [3:0] format_code;
   logic [3:0] seen_format;
   logic serdes_quad_reset, serdes_tx_ref_clock, serdes_rx_ref_clock, rx_rate_clock_request;
   logic parallel_video_clock, high_rate_indicator, trs_marker, video_locked;
   logic video_field, vertical_blank, horizontal_blank;
   logic sci_select, sci_enable, sci_read, sci_write;
   int bad_count = 0;
   int checked = 0;
   always #2 ref_clk = ~ref_clk;
   // slow enough that a full sd line fits well inside the watchdog span
   always #2000 static_watchdog_clock = ~static_watchdog_clock;
   srx_phy_rx_timing_outputs #(.LOCK_LINES(2), .WD_TIMEOUT_TICKS(4)) i_dut (
      .ref_clk, .reset_n, .core_enable, .static_watchdog_clock, .deser_data,
      .serdes_quad_reset, .tx_core_ref_clock, .rx_core_ref_clock, .serdes_tx_ref_clock,
      .serdes_rx_ref_clock, .scan_disable, .rate_select, .rx_rate_clock_request,
      .parallel_video_out, .parallel_video_clock, .high_rate_indicator, .trs_marker,
      .video_locked, .format_code, .video_field, .vertical_blank, .horizontal_blank,
      .sci_select, .sci_enable, .sci_read, .sci_write, .sci_address, .sci_write_data,
      .sci_read_data);
   srx_downstream_model i_far (.parallel_video_clock, .video_locked, .format_code,
      .seen_format, .sci_select, .sci_read, .sci_write, .sci_write_data, .sci_read_data);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
      checked++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask
   task automatic put(logic [DATA_W-1:0] w);
      @(negedge ref_clk);
      deser_data = w;
   endtask
   task automatic done(string t);
      $display("test %s finished", t);
   endtask
   // one line: trs first word, two zeros, status word, then zero padding
   task automatic line(logic [DATA_W-1:0] first, logic [9:0] st, int len);
      logic hd;
      logic [DATA_W-1:0] exp;
      hd = (first === TRS_FIRST_HD);
      exp = hd ? first : {10'h0, first[9:0]};
      for (int i = 0; i < len; i++) begin
         put(i == 0 ? first : i == 3 ? {10'h0, st} : 20'h0);
         if (i == 4) begin
            chk("first word", exp, parallel_video_out);
            chk("marker", 20'h1, 20'(trs_marker));
            chk("rate flag", 20'(hd), 20'(high_rate_indicator));
         end
         if (i == 5) chk("marker end", 20'h0, 20'(trs_marker));
         if (i == 7) chk("status out", {10'h0, st}, parallel_video_out);
         if (i == 8) chk("flags", 20'(st[8:6]), 20'({video_field, vertical_blank, horizontal_blank}));
         if (i == len - 1) chk("flags held", 20'(st[8:6]), 20'({video_field, vertical_blank, horizontal_blank}));
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #300000;
      bad_count++;
      final_report();
   end
   initial begin
      repeat (10) @(negedge ref_clk);
      chk("quad reset", 20'h1, 20'(serdes_quad_reset));
      chk("reset request", 20'h0, 20'(rx_rate_clock_request));
      chk("tx ref off", 20'h0, 20'(serdes_tx_ref_clock));
      chk("rx ref off", 20'h0, 20'(serdes_rx_ref_clock));
      reset_n = 1'h1;
      done("reset");
      line(20'h5a3ff, 10'h3c0, 12);
      core_enable = 1'h0;
      for (int i = 0; i < 8; i++) put(i == 0 ? 20'h003ff : i == 3 ? 20'h240 : 20'h0);
      chk("frozen flags", 20'h7, 20'({video_field, vertical_blank, horizontal_blank}));
      chk("frozen marker", 20'h0, 20'(trs_marker));
      chk("out clock", 20'(ref_clk), 20'(parallel_video_clock));
      core_enable = 1'h1;
      done("flags and freeze");
      repeat (6) line(20'h003ff, 10'h240, int'(FMT_LEN[0]));
      chk("locked", 20'h1, 20'(video_locked));
      chk("format", 20'(FMT_CODE[0]), 20'(format_code));
      chk("seen format", 20'(FMT_CODE[0]), 20'(seen_format));
      chk("sd request", 20'h0, 20'(rx_rate_clock_request));
      scan_disable = 1'h1;
      line(20'h003ff, 10'h240, 900);
      line(20'h003ff, 10'h240, 40);
      chk("held lock", 20'h1, 20'(video_locked));
      scan_disable = 1'h0;
      line(20'h003ff, 10'h240, 900);
      line(20'h003ff, 10'h240, 40);
      chk("lost lock", 20'h0, 20'(video_locked));
      done("lock");
      rate_select = RATE_BOTH;
      for (int n = 0; n < 30000 && rx_rate_clock_request !== 1'h1; n++) @(negedge ref_clk);
      chk("hd request", 20'h1, 20'(rx_rate_clock_request));
      chk("lock at change", 20'h0, 20'(video_locked));
      line(TRS_FIRST_HD, 10'h200, 12);
      done("rate change");
      // reprogramming waits for the next watchdog tick after the switch
      for (int n = 0; n < 1100 && sci_write !== 1'h1; n++) @(negedge ref_clk);
      chk("cfg strobes", 20'h3, 20'({sci_select, sci_enable}));
      chk("cfg address", 20'(SCI_ADDR_RATE), 20'(sci_address));
      chk("cfg data", 20'(SCI_VAL_HD), 20'(sci_write_data));
      @(negedge ref_clk);
      chk("cfg read", 20'h1, 20'(sci_read));
      rate_select = RATE_SD_ONLY;
      @(negedge ref_clk);
      chk("sd only", 20'h0, 20'(rx_rate_clock_request));
      rate_select = 2'h1;
      @(negedge ref_clk);
      chk("hd only", 20'h1, 20'(rx_rate_clock_request));
      done("config and modes");
      @(negedge ref_clk);
      #1 reset_n = 1'h0;
      #0.5 chk("async clear", 20'h0, 20'(rx_rate_clock_request));
      done("async reset");
      final_report();
   end
endmodule
`default_nettype wire
